// *** dcff_top.sv ***
// Dual clock flag fifo: pin sampling, pointers, offsets, flags and output register
//
`timescale 1ns/100ps
module dcff_top
    import dcff_pkg::*;
#(
    parameter int DEPTH = dcff_pkg::DEPTH_DEF
) (
    input  wire logic                   clk,                   // 20 MHz system clock
    input  wire logic                   srst,                  // Synchronous reset, active high
    input  wire logic [dcff_pkg::DW-1:0] write_data_bus,       // Write word
    input  wire logic                   write_clock,           // Producer clock pin
    input  wire logic                   write_enable_n,        // Write enable
    input  wire logic                   read_clock,            // Consumer clock pin
    input  wire logic                   read_enable_n,         // Read enable
    input  wire logic                   master_clear_n,        // Master clear
    input  wire logic                   partial_clear_n,       // Partial clear
    input  wire logic                   reread_request_n,      // Reread from first location
    input  wire logic                   mode_select_serial_in, // Mode strap / serial offset bit
    input  wire logic                   serial_load_enable_n,  // Serial offset load enable
    input  wire logic                   offset_load_n,         // Offset access qualifier
    input  wire logic                   output_enable_n,       // Data output drive enable
    input  wire logic                   unused_strap,          // Held constant, no function
    output logic      [dcff_pkg::DW-1:0] read_data_bus,        // Output register
    output logic                        read_data_oe,          // Drive enable for read_data_bus
    output logic                        full_or_input_ready_n, // Full flag / input ready
    output logic                        empty_or_output_ready_n, // Empty flag / output ready
    output logic                        almost_full_flag_n,    // Almost full
    output logic                        almost_empty_flag_n,   // Almost empty
    output logic                        half_full_flag_n       // Half full
);
    import dcff_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0]   DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0]   HALF_C  = (AW+1)'(DEPTH / 2);
    localparam logic [AW-1:0] OFS_PAR = AW'(DEF_OFS_PAR);
    localparam logic [AW-1:0] OFS_SER = AW'(DEF_OFS_SER);
    localparam logic [1:0]    EDGE_LAST = 2'(FALL_EDGES - 1);

    if ((1 << AW) != DEPTH || AW < MIN_AW || AW > MAX_AW) begin : g_chk
        $error("dcff_top: depth must be a power of two from 2048 to 262144");
    end

    typedef struct packed {
        logic          wclk_d;  // Previous write clock level
        logic          rclk_d;  // Previous read clock level
        logic          fall_through_mode;    // Fall-through timing selected
        logic          ser;     // Serial offset programming selected
        logic [AW:0]   wptr;
        logic [AW:0]   rptr;
        logic [AW-1:0] ofs_e;   // Empty offset n
        logic [AW-1:0] ofs_f;   // Full offset m
        logic [1:0]    wpart;   // Next parallel part to load
        logic [1:0]    rpart;   // Next parallel part to read back
        logic [DW-1:0] dout;
        logic          fetch;   // Memory read in flight
        logic          ov;      // Valid word shown (fall-through)
        logic [1:0]    edges;   // Read clock transitions seen while waiting
        logic          rt_hold; // Empty shown after reread
        logic          oe;
        logic          ff_n;
        logic          ef_n;
        logic          paf_n;
        logic          pae_n;
        logic          hf_n;
    } dcff_st_s;

    dcff_st_s   s;
    dcff_st_s   next_s;
    dcff_pins_s raw;
    dcff_pins_s p;
    logic          mem_we;
    logic          mem_re;
    logic [DW-1:0] mem_rdata;
    logic          clr;
    logic          wr_rise;
    logic          rd_rise;
    logic          rd_tr;
    logic [AW:0]   cnt_now;
    logic [AW:0]   cnt_nxt;
    logic          full_now;
    logic          empty_now;
    logic          full_nxt;

    // Pins come from two unrelated clocks, so every one but unused_strap is synchronised
    always_comb begin
        raw         = '0;
        raw.mclr_n  = master_clear_n;
        raw.pclr_n  = partial_clear_n;
        raw.rt_n    = reread_request_n;
        raw.mode_si = mode_select_serial_in;
        raw.wen_n   = write_enable_n;
        raw.ren_n   = read_enable_n;
        raw.sen_n   = serial_load_enable_n;
        raw.ld_n    = offset_load_n;
        raw.oe_n    = output_enable_n;
        raw.wclk    = write_clock;
        raw.rclk    = read_clock;
        raw.wdata   = write_data_bus;
    end

    dcff_sync #(
        .W($bits(dcff_pins_s))
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .d    (raw),
        .q    (p)
    );

    dcff_mem #(
        .DEPTH(DEPTH),
        .W    (DW)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (s.wptr[AW-1:0]),
        .wdata (p.wdata),
        .re    (mem_re),
        .raddr (s.rptr[AW-1:0]),
        .rdata (mem_rdata)
    );

    // Clock pins run far below clk, so their edges become one-cycle events
    assign clr       = !p.mclr_n || !p.pclr_n;
    assign wr_rise   = p.wclk && !s.wclk_d;
    assign rd_rise   = p.rclk && !s.rclk_d;
    assign rd_tr     = p.rclk ^ s.rclk_d;
    assign cnt_now   = s.wptr - s.rptr;
    assign full_now  = cnt_now == DEPTH_C;
    assign empty_now = cnt_now == '0;

    always_comb begin
        next_s        = s;
        mem_we        = 1'b0;
        mem_re        = 1'b0;
        next_s.wclk_d = p.wclk;
        next_s.rclk_d = p.rclk;
        next_s.oe     = !p.oe_n;
        if (clr) begin
            next_s.wptr    = '0;
            next_s.rptr    = '0;
            next_s.dout    = '0;
            next_s.fetch   = 1'b0;
            next_s.ov      = 1'b0;
            next_s.edges   = '0;
            next_s.rt_hold = 1'b0;
            next_s.wpart   = PART_E_LO;
            next_s.rpart   = PART_E_LO;
            if (!p.mclr_n) begin
                next_s.fall_through_mode  = p.mode_si;
                next_s.ser   = p.ld_n;
                next_s.ofs_e = p.ld_n ? OFS_SER : OFS_PAR;
                next_s.ofs_f = p.ld_n ? OFS_SER : OFS_PAR;
            end
        end else begin
            // A fetched word lands in the output register
            if (s.fetch) begin
                next_s.fetch = 1'b0;
                next_s.dout  = mem_rdata;
                if (s.fall_through_mode) begin
                    next_s.ov = 1'b1;
                end
            end
            // Write side
            if (wr_rise && !p.ld_n) begin
                if (!p.wen_n && !s.ser) begin
                    case (s.wpart)
                        PART_E_LO: next_s.ofs_e[8:0]    = p.wdata;
                        PART_E_HI: next_s.ofs_e[AW-1:9] = p.wdata[AW-10:0];
                        PART_F_LO: next_s.ofs_f[8:0]    = p.wdata;
                        PART_F_HI: next_s.ofs_f[AW-1:9] = p.wdata[AW-10:0];
                        default:   next_s.ofs_e         = s.ofs_e;
                    endcase
                    next_s.wpart = s.wpart + 2'h1;
                end else if (!p.sen_n && s.ser) begin
                    // First bit ends up as the empty offset LSB
                    {next_s.ofs_f, next_s.ofs_e} = {p.mode_si, s.ofs_f, s.ofs_e[AW-1:1]};
                end
            end else if (wr_rise && !p.wen_n && !full_now) begin
                mem_we      = 1'b1;
                next_s.wptr = s.wptr + 1'b1;
            end
            // Read side; reread outranks a read on the same edge
            if (rd_rise) begin
                next_s.rt_hold = 1'b0;
            end
            if (rd_rise && !p.rt_n) begin
                next_s.rptr    = '0;
                next_s.ov      = 1'b0;
                next_s.edges   = '0;
                next_s.fetch   = 1'b0;
                next_s.rt_hold = !s.fall_through_mode;
            end else if (rd_rise && !p.ren_n && !p.ld_n) begin
                case (s.rpart)
                    PART_E_LO: next_s.dout = s.ofs_e[8:0];
                    PART_E_HI: next_s.dout = DW'(s.ofs_e[AW-1:9]);
                    PART_F_LO: next_s.dout = s.ofs_f[8:0];
                    PART_F_HI: next_s.dout = DW'(s.ofs_f[AW-1:9]);
                    default:   next_s.dout = s.dout;
                endcase
                next_s.rpart = s.rpart + 2'h1;
            end else if (rd_rise && !p.ren_n && !s.fetch) begin
                if (!empty_now) begin
                    mem_re       = 1'b1;
                    next_s.fetch = 1'b1;
                    next_s.rptr  = s.rptr + 1'b1;
                end else if (s.fall_through_mode) begin
                    next_s.ov = 1'b0;                                     // Shown word consumed
                end
            end else if (s.fall_through_mode && !s.ov && !s.fetch) begin
                // First word falls through after the third transition
                if (empty_now) begin
                    next_s.edges = '0;
                end else if (rd_tr && s.edges == EDGE_LAST) begin
                    mem_re       = 1'b1;
                    next_s.fetch = 1'b1;
                    next_s.rptr  = s.rptr + 1'b1;
                    next_s.edges = '0;
                end else if (rd_tr) begin
                    next_s.edges = s.edges + 2'h1;
                end
            end
        end
        // Write-side flags move on write edges, read-side on read edges, except fall-through ef_n, which follows ov every cycle
        cnt_nxt  = next_s.wptr - next_s.rptr;
        full_nxt = cnt_nxt == DEPTH_C;
        if (clr || wr_rise) begin
            next_s.ff_n  = next_s.fall_through_mode ? full_nxt : !full_nxt;
            next_s.paf_n = !(cnt_nxt > DEPTH_C - {1'b0, next_s.ofs_f});
            next_s.hf_n  = !(cnt_nxt > HALF_C);
        end
        if (clr || rd_rise) begin
            next_s.pae_n = !(cnt_nxt < {1'b0, next_s.ofs_e});
            next_s.ef_n  = !(cnt_nxt == '0 || next_s.rt_hold);
        end
        if (next_s.fall_through_mode) begin
            next_s.ef_n = !next_s.ov;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s       <= '0;
            s.ef_n  <= 1'b0;
            s.ff_n  <= 1'b1;
            s.paf_n <= RST_ALMOST_FULL_N;
            s.pae_n <= RST_ALMOST_EMPTY_N;
            s.hf_n  <= RST_HALF_N;
            s.ofs_e <= OFS_PAR;
            s.ofs_f <= OFS_PAR;
            // Edge detectors start at the pin level so reset never fakes a clock edge
            s.wclk_d <= p.wclk;
            s.rclk_d <= p.rclk;
        end else begin
            s <= next_s;
        end
    end

    assign read_data_bus           = s.dout;
    assign read_data_oe            = s.oe;
    assign full_or_input_ready_n   = s.ff_n;
    assign empty_or_output_ready_n = s.ef_n;
    assign almost_full_flag_n      = s.paf_n;
    assign almost_empty_flag_n     = s.pae_n;
    assign half_full_flag_n        = s.hf_n;

    sequence fall_arm_q;
        s.fall_through_mode && !s.ov && !s.fetch && !empty_now && rd_tr && s.edges == EDGE_LAST && !clr
            && !(rd_rise && (!p.rt_n || !p.ren_n));
    endsequence
    sequence fall_land_q;
        s.fetch ##1 (s.ov && !s.fetch);
    endsequence
    sequence std_read_q;
        !s.fall_through_mode && rd_rise && !p.ren_n && p.ld_n && p.rt_n && !s.fetch && !empty_now && !clr;
    endsequence

    mclr_zero_a: assert property (@(posedge clk) disable iff (srst)
        !p.mclr_n |=> (s.wptr == '0 && s.rptr == '0 && s.dout == '0 && !s.fetch))
        else $error("master clear left pointers or output set");
    cfg_latch_a: assert property (@(posedge clk) disable iff (srst)
        !p.mclr_n |=> (s.fall_through_mode == $past(p.mode_si) && s.ser == $past(p.ld_n)))
        else $error("master clear did not latch configuration");
    dflt_ofs_a: assert property (@(posedge clk) disable iff (srst)
        !p.mclr_n |=> (s.ofs_e == s.ofs_f && s.ofs_e == (s.ser ? OFS_SER : OFS_PAR)))
        else $error("default offset does not match programming method");
    pclr_keep_a: assert property (@(posedge clk) disable iff (srst)
        (p.mclr_n && !p.pclr_n) |=> (s.wptr == '0 && s.rptr == '0 && $stable(s.fall_through_mode)
            && $stable(s.ser) && $stable(s.ofs_e) && $stable(s.ofs_f)))
        else $error("partial clear disturbed configuration");
    reread_a: assert property (@(posedge clk) disable iff (srst)
        (rd_rise && !p.rt_n && !clr) |=> (s.rptr == '0 && !s.ov && (s.fall_through_mode || !s.ef_n)))
        else $error("reread did not rewind and show empty");
    no_overrun_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !p.wen_n && p.ld_n && full_now && !clr) |=> s.wptr == $past(s.wptr))
        else $error("write accepted while full");
    full_flag_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !clr) |=> s.ff_n == (s.fall_through_mode ? (s.wptr - s.rptr == DEPTH_C) : (s.wptr - s.rptr != DEPTH_C)))
        else $error("full or input ready flag wrong after write edge");
    almost_full_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !clr) |=> s.paf_n == !(s.wptr - s.rptr > DEPTH_C - {1'b0, s.ofs_f}))
        else $error("almost full flag wrong after write edge");
    almost_empty_a: assert property (@(posedge clk) disable iff (srst)
        (rd_rise && !clr) |=> s.pae_n == !(s.wptr - s.rptr < {1'b0, s.ofs_e}))
        else $error("almost empty flag wrong after read edge");
    fall_first_a: assert property (@(posedge clk) disable iff (srst)
        fall_arm_q |=> fall_land_q ##1 !s.ef_n)
        else $error("first word did not fall through on third transition");
    std_read_a: assert property (@(posedge clk) disable iff (srst)
        std_read_q |=> s.fetch ##1 (s.dout == $past(mem_rdata)))
        else $error("standard read did not present next word");
    out_drive_a: assert property (@(posedge clk) disable iff (srst)
        $changed(p.oe_n) |=> read_data_oe == !$past(p.oe_n))
        else $error("output drive does not follow enable");

    // Offset access, configuration hold, flag follow-up, underrun and reread side effects
    half_full_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !clr) |=> s.hf_n == !(s.wptr - s.rptr > HALF_C))
        else $error("half full flag wrong after write edge");
    std_empty_a: assert property (@(posedge clk) disable iff (srst)
        (!s.fall_through_mode && rd_rise && p.rt_n && !clr) |=> s.ef_n == (s.wptr != s.rptr))
        else $error("empty flag wrong after read edge");
    ready_valid_a: assert property (@(posedge clk) disable iff (srst)
        s.fall_through_mode |-> s.ef_n == !s.ov)
        else $error("output ready does not follow shown word");
    no_underrun_a: assert property (@(posedge clk) disable iff (srst)
        (rd_rise && !p.ren_n && p.ld_n && p.rt_n && empty_now && !clr) |=> s.rptr == $past(s.rptr))
        else $error("read accepted while empty");
    par_load_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !p.ld_n && !p.wen_n && !s.ser && s.wpart == PART_E_LO && !clr)
            |=> s.ofs_e[8:0] == $past(p.wdata))
        else $error("parallel offset part not loaded");
    serial_shift_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !p.ld_n && !p.sen_n && s.ser && !clr)
            |=> (s.ofs_f[AW-1] == $past(p.mode_si) && s.ofs_e[AW-1] == $past(s.ofs_f[0])))
        else $error("serial offset bit not shifted in");
    ofs_redirect_a: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && !p.ld_n && !clr) |=> s.wptr == $past(s.wptr))
        else $error("offset access moved the write pointer");
    cfg_hold_a: assert property (@(posedge clk) disable iff (srst)
        p.mclr_n |=> ($stable(s.fall_through_mode) && $stable(s.ser)))
        else $error("configuration changed outside master clear");
    rt_keep_a: assert property (@(posedge clk) disable iff (srst)
        (rd_rise && !p.rt_n && !clr && !wr_rise)
            |=> ($stable(s.wptr) && $stable(s.ofs_e) && $stable(s.ofs_f)))
        else $error("reread disturbed write side or offsets");
endmodule

// *** dcff_pkg.sv ***
// Shared constants and carriers for the dual clock flag fifo
package dcff_pkg;
    localparam int DW          = 9;     // Word width
    localparam int DEPTH_DEF   = 16384; // Default capacity in words
    localparam int DEF_OFS_PAR = 127;   // Default offset with parallel loading
    localparam int DEF_OFS_SER = 1023;  // Default offset with serial loading
    localparam int FALL_EDGES  = 3;     // Read clock transitions before first word falls through
    localparam int MIN_AW      = 11;    // Offsets up to 1023 need deeper memory
    localparam int MAX_AW      = 18;    // Upper bound of the offset part scheme
    // Parallel offset parts, in load and read-back order
    localparam logic [1:0] PART_E_LO = 2'h0;
    localparam logic [1:0] PART_E_HI = 2'h1;
    localparam logic [1:0] PART_F_LO = 2'h2;
    localparam logic [1:0] PART_F_HI = 2'h3;
    // Flag levels loaded by reset
    localparam logic RST_ALMOST_FULL_N = 1'b1;
    localparam logic RST_ALMOST_EMPTY_N = 1'b0;
    localparam logic RST_HALF_N        = 1'b1;

    typedef struct packed {
        logic          mclr_n;  // Master clear
        logic          pclr_n;  // Partial clear
        logic          rt_n;    // Reread request
        logic          mode_si; // Mode select / serial input
        logic          wen_n;   // Write enable
        logic          ren_n;   // Read enable
        logic          sen_n;   // Serial load enable
        logic          ld_n;    // Offset load
        logic          oe_n;    // Output drive enable
        logic          wclk;    // Write clock pin
        logic          rclk;    // Read clock pin
        logic [DW-1:0] wdata;   // Write data bus
    } dcff_pins_s;
endpackage

// *** dcff_sync.sv ***
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module dcff_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,  // System clock
    input  wire logic         srst, // Synchronous reset
    input  wire logic [W-1:0] d,    // Asynchronous levels
    output logic      [W-1:0] q     // Synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcff_sync_s;

    dcff_sync_s s;
    dcff_sync_s next_s;

    if (W < 1) begin : g_chk
        $error("dcff_sync: width must be positive");
    end

    always_comb begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1; // Only the second stage ever reads the first
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // Preload the pin levels so release of reset never fakes an edge or a clear
            s <= '{s1: d, s2: d};
        end else begin
            s <= next_s;
        end
    end

    assign q = s.s2;
endmodule

// *** dcff_mem.sv ***
// Word memory with one write port and a registered read port
`timescale 1ns/100ps
module dcff_mem #(
    parameter int DEPTH = 16384,
    parameter int W     = 9
) (
    input  wire logic                     clk,   // System clock
    input  wire logic                     we,    // Write strobe
    input  wire logic [$clog2(DEPTH)-1:0] waddr, // Write address
    input  wire logic [W-1:0]             wdata, // Write word
    input  wire logic                     re,    // Read strobe
    input  wire logic [$clog2(DEPTH)-1:0] raddr, // Read address
    output logic      [W-1:0]             rdata  // Read word, one cycle after re
);
    logic [W-1:0] mem [DEPTH];

    if (DEPTH < 2 || W < 1) begin : g_chk
        $error("dcff_mem: unusable geometry");
    end

    // No reset: contents are undefined until written, like the real array
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// *** dcff_far.sv ***
// Producer and consumer pin model facing the dual clock flag fifo
`timescale 1ns/100ps
module dcff_far
    import dcff_pkg::*;
(
    input  wire logic                    clk,                   // System clock
    output logic      [dcff_pkg::DW-1:0] write_data_bus,        // Write word
    output logic                         write_clock,           // Producer clock pin
    output logic                         write_enable_n,        // Write enable
    output logic                         read_clock,            // Consumer clock pin
    output logic                         read_enable_n,         // Read enable
    output logic                         mode_select_serial_in, // Mode strap / serial bit
    output logic                         serial_load_enable_n,  // Serial offset load
    output logic                         offset_load_n          // Offset qualifier
);
    initial begin
        write_data_bus = '0;
        {write_clock, read_clock, mode_select_serial_in} = 3'h0;
        {write_enable_n, read_enable_n, serial_load_enable_n, offset_load_n} = 4'hf;
    end
    // Pin clocks keep each phase well above the two-flop sampling window
    task automatic rise(input bit w);
        repeat (3) @(posedge clk);
        if (w) write_clock <= 1'b1; else read_clock <= 1'b1;
        repeat (4) @(posedge clk);
        if (w) write_clock <= 1'b0; else read_clock <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic cfg(input logic mode, input logic ld);
        mode_select_serial_in <= mode;
        offset_load_n         <= ld;
    endtask
    task automatic wr(input logic [DW-1:0] d, input logic ld, input logic ser);
        write_data_bus        <= d;
        mode_select_serial_in <= d[0];
        offset_load_n         <= ld;
        write_enable_n        <= ser;
        serial_load_enable_n  <= !ser;
        rise(1'b1);
        {write_enable_n, serial_load_enable_n, offset_load_n} <= 3'h7;
        // Released bus shows the inverse so stale data cannot pass unseen
        write_data_bus        <= ~d;
        mode_select_serial_in <= !d[0];
        @(posedge clk);
    endtask
    task automatic rd(input logic ld, input logic en);
        read_enable_n <= !en;
        offset_load_n <= ld;
        rise(1'b0);
        read_enable_n <= 1'b1;
        offset_load_n <= 1'b1;
        // Let an edge pass so a following call never reassigns a pin in this time step
        @(posedge clk);
    endtask
    task automatic rtog(input logic v);
        repeat (4) @(posedge clk);
        read_clock <= v;
    endtask
endmodule

// *** test_dual_clock_flag_fifo.sv ***
// Self-checking bench for the dual clock flag fifo
`timescale 1ns/100ps
module test_dual_clock_flag_fifo;
    import dcff_pkg::*;
    localparam int D = 2048;
    logic          clk = 0, srst = 1, master_clear_n = 1, partial_clear_n = 1;
    logic          reread_request_n = 1, output_enable_n = 1, unused_strap = 0;
    logic [DW-1:0] wdb, rdb;
    logic          wclk, wen_n, rclk, ren_n, msi, sen_n, ld_n, oe, ff_n, ef_n, af_n, ae_n, hf_n;
    int            error_cnt = 0;
    int            compares = 0;
    always #25 clk = ~clk;
    dcff_far i_dcff_far (.clk(clk), .write_data_bus(wdb), .write_clock(wclk), .write_enable_n(wen_n),
        .read_clock(rclk), .read_enable_n(ren_n), .mode_select_serial_in(msi),
        .serial_load_enable_n(sen_n), .offset_load_n(ld_n));
    dcff_top #(.DEPTH(D)) i_dcff_top (.clk(clk), .srst(srst), .write_data_bus(wdb), .write_clock(wclk),
        .write_enable_n(wen_n), .read_clock(rclk), .read_enable_n(ren_n), .master_clear_n(master_clear_n),
        .partial_clear_n(partial_clear_n), .reread_request_n(reread_request_n), .mode_select_serial_in(msi),
        .serial_load_enable_n(sen_n), .offset_load_n(ld_n), .output_enable_n(output_enable_n),
        .unused_strap(unused_strap), .read_data_bus(rdb), .read_data_oe(oe), .full_or_input_ready_n(ff_n),
        .empty_or_output_ready_n(ef_n), .almost_full_flag_n(af_n), .almost_empty_flag_n(ae_n),
        .half_full_flag_n(hf_n));
    task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic clr(input bit m, input logic mode, input logic ld);
        if (m) i_dcff_far.cfg(mode, ld);
        if (m) master_clear_n <= 1'b0; else partial_clear_n <= 1'b0;
        repeat (6) @(posedge clk);
        {master_clear_n, partial_clear_n} <= 2'h3;
        // Strap pins move only after the clear release has passed the syncs
        repeat (5) @(posedge clk);
        i_dcff_far.cfg(1'b0, 1'b1);
        repeat (2) @(posedge clk);
    endtask
    task automatic ofs(input logic [DW-1:0] a, b, c, d);
        logic [DW-1:0] p[4];
        p = '{a, b, c, d};
        for (int k = 0; k < 4; k++) begin
            i_dcff_far.rd(1'b0, 1'b1);
            chk("offset part", rdb, p[k]);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        output_enable_n <= 1'b0;
        clr(1, 1'b0, 1'b0);
        chk("empty", ef_n, 0);
        chk("full", ff_n, 1); chk("almost full", af_n, 1); chk("half", hf_n, 1);
        chk("almost empty", ae_n, 0); chk("dout", rdb, 0); chk("oe", oe, 1);
        ofs(127, 0, 127, 0);
        i_dcff_far.rd(1'b1, 1'b1);
        chk("dout", rdb, 0);
        i_dcff_far.wr(9'h1a5, 1'b1, 1'b0);
        i_dcff_far.wr(9'h05a, 1'b1, 1'b0);
        i_dcff_far.rd(1'b1, 1'b1);
        chk("dout", rdb, 9'h1a5); chk("empty", ef_n, 1);
        i_dcff_far.rd(1'b1, 1'b1);
        chk("dout", rdb, 9'h05a); chk("empty", ef_n, 0);
        reread_request_n <= 1'b0;
        i_dcff_far.rd(1'b1, 1'b0);
        reread_request_n <= 1'b1;
        chk("empty", ef_n, 0);
        i_dcff_far.rd(1'b1, 1'b1);
        chk("dout", rdb, 9'h1a5);
        $display("test standard done");
        clr(0, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) i_dcff_far.wr(k[0] ? 9'h0 : 9'h5, 1'b0, 1'b0);
        for (int i = 1; i <= D; i++) begin
            i_dcff_far.wr(i[8:0], 1'b1, 1'b0);
            chk("half", hf_n, (i > D / 2) ? 0 : 1);
            chk("almost full", af_n, (i > D - 5) ? 0 : 1);
            chk("full", ff_n, (i == D) ? 0 : 1);
        end
        i_dcff_far.wr(9'h1aa, 1'b1, 1'b0);
        i_dcff_far.rd(1'b1, 1'b1);
        chk("dout", rdb, 9'h001);
        clr(0, 1'b0, 1'b0);
        ofs(5, 0, 5, 0);
        chk("almost empty", ae_n, 0); chk("empty", ef_n, 0); chk("dout", rdb, 0);
        $display("test fill done");
        clr(1, 1'b1, 1'b1);
        ofs(9'h1ff, 1, 9'h1ff, 1);
        for (int i = 0; i < 22; i++) i_dcff_far.wr(9'((i % 11) < 2), 1'b0, 1'b1);
        ofs(3, 0, 3, 0);
        i_dcff_far.wr(9'h0c3, 1'b1, 1'b0);
        chk("input ready", ff_n, 0); chk("output ready", ef_n, 1);
        i_dcff_far.rtog(1'b1);
        i_dcff_far.rtog(1'b0);
        i_dcff_far.rtog(1'b1);
        repeat (8) @(posedge clk);
        chk("dout", rdb, 9'h0c3); chk("output ready", ef_n, 0);
        chk("almost empty", ae_n, 0);
        i_dcff_far.rtog(1'b0);
        output_enable_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("oe", oe, 0);
        $display("test fall-through done");
        test_done();
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule
